// *** rtl/dac_ctl_pkg.sv ***
// constants shared by the dual converter control logic
// Summary of operation
// - two registers per channel: holding, output
// - holding registers load without touching outputs
// - transparent load writes output register directly
// - output changes only with its output register
// - reset powers channels down, 100k termination
// - reset clears holding and output registers
// - power commands accepted any time
// - code field is straight unsigned binary
// - input ignored after sixteenth bit
// - select falling edge re-arms the input
// - 16-bit word, msb first, command on top
// - 0000/0001 transparent load A/B
// - 0100/0101 holding load A/B only
// - 1000/1001 holding to output A/B
// - 1100 transparent load both channels
// - 1101 holding load both channels
// - 1110 transfer both holding registers
// - 1111 power control by code bits
// - sample on falling shift clock edges
// - early select rise discards partial word
// - power-down keeps register contents
package dac_ctl_pkg;
   localparam int WORD_W = 16;
   localparam int CODE_W = 12;
   localparam int ADDR_W = 8;
   localparam logic [3:0] CMD_XPAR_A = 4'h0;
   localparam logic [3:0] CMD_XPAR_B = 4'h1;
   localparam logic [3:0] CMD_HOLD_A = 4'h4;
   localparam logic [3:0] CMD_HOLD_B = 4'h5;
   localparam logic [3:0] CMD_XFER_A = 4'h8;
   localparam logic [3:0] CMD_XFER_B = 4'h9;
   localparam logic [3:0] CMD_XPAR_AB = 4'hC;
   localparam logic [3:0] CMD_HOLD_AB = 4'hD;
   localparam logic [3:0] CMD_XFER_AB = 4'hE;
   localparam logic [3:0] CMD_POWER = 4'hF;
   localparam int PWR_BOTH_BIT = 4;
   localparam int PWR_SEL_B_BIT = 2;
   localparam logic [1:0] PD_WAKE = 2'h0;
   localparam logic [1:0] PD_FLOAT = 2'h1;
   localparam logic [1:0] PD_1K = 2'h2;
   localparam logic [1:0] PD_100K = 2'h3;
   localparam logic [1:0] PD_RST = PD_100K;
   localparam logic [11:0] CODE_RST = 12'h000;
   localparam logic CTRL_EN_RST = 1'b1;
   localparam int CTRL_EN_BIT = 0;
   localparam logic [7:0] OFF_CTRL = 8'h00;
   localparam logic [7:0] OFF_CMD = 8'h04;
   localparam logic [7:0] OFF_CHAN_A = 8'h08;
   localparam logic [7:0] OFF_CHAN_B = 8'h0C;
   localparam logic [7:0] OFF_STATUS = 8'h10;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_DECERR = 2'h3;
   localparam int CLK_MHZ = 50;
   localparam int WAKE_NS = 8000;
   localparam int WAKE_CYC = (WAKE_NS * CLK_MHZ + 999) / 1000;
   localparam logic [4:0] LAST_BIT = 5'h0F;
endpackage

// *** rtl/frame_if.sv ***
// carrier for received frames between link receiver and core
`timescale 1ns/100ps
`default_nettype none
interface frame_if;
   logic valid;
   logic [15:0] word;
   logic armed;
   modport rx (output valid, output word, output armed);
   modport core (input valid, input word, input armed);
endinterface
`default_nettype wire

// *** rtl/link_rx.sv ***
// serial frame receiver sampled on the system clock
`timescale 1ns/100ps
`default_nettype none
module link_rx (
   input wire logic i_ref_clk,
   input wire logic i_srst,
   input wire logic i_link_en,
   input wire logic i_frame_sel_n,
   input wire logic i_shift_clk,
   input wire logic i_serial_data,
   frame_if.rx frame
);
   typedef struct packed {
      logic [2:0] s1;
      logic [2:0] s2;
      logic sck_prev;
      logic sel_prev;
      logic armed;
      logic [4:0] cnt;
      logic [15:0] shreg;
      logic valid;
      logic [15:0] word;
   } rx_t;
   rx_t q;
   rx_t n;
   logic sel_n;
   logic sck;

   assign sel_n = q.s2[2];
   assign sck = q.s2[1];

   always_comb
   begin
      n = q;
      n.valid = 1'b0;
      n.s1 = {i_frame_sel_n, i_shift_clk, i_serial_data};
      n.s2 = q.s1;
      n.sck_prev = sck;
      n.sel_prev = sel_n;
      if (q.sel_prev && !sel_n && i_link_en)
      begin
         n.armed = 1'b1;
         n.cnt = 5'h00;
      end
      else if (q.armed && sel_n)
      begin
         n.armed = 1'b0;
      end
      else if (q.armed && q.sck_prev && !sck)
      begin
         n.shreg = {q.shreg[14:0], q.s2[0]};
         n.cnt = q.cnt + 5'h01;
         if (q.cnt == dac_ctl_pkg::LAST_BIT)
         begin
            n.armed = 1'b0;
            n.valid = 1'b1;
            n.word = {q.shreg[14:0], q.s2[0]};
         end
      end
   end

   always_ff @(posedge i_ref_clk)
   begin
      if (i_srst)
         q <= '{s1: 3'h7, s2: 3'h7, sck_prev: 1'b1, sel_prev: 1'b1, default: '0};
      else
         q <= n;
   end

   assign frame.valid = q.valid;
   assign frame.word = q.word;
   assign frame.armed = q.armed;

   default clocking cb @(posedge i_ref_clk); endclocking
   default disable iff (i_srst);

   early_rise_drop_a: assert property (q.armed && sel_n |=> !q.armed && !q.valid)
      else $error("partial frame not discarded");
   rearm_edge_a: assert property (q.sel_prev && !sel_n && i_link_en |=> q.armed && q.cnt == 5'h00)
      else $error("select fall did not arm receiver");
   sixteen_bits_a: assert property (q.valid |-> !q.armed && $past(q.cnt) == 5'h0F)
      else $error("frame delivered at wrong bit count");
endmodule // link_rx
`default_nettype wire

// *** rtl/wake_timer.sv ***
// recovery timer started by a wake-up command
`timescale 1ns/100ps
`default_nettype none
module wake_timer (
   input wire logic i_ref_clk,
   input wire logic i_srst,
   input wire logic i_start,
   output logic o_busy
);
   typedef struct packed {
      logic [8:0] cnt;
      logic busy;
   } wt_t;
   wt_t q;
   wt_t n;

   always_comb
   begin
      n = q;
      if (i_start)
      begin
         n.cnt = 9'(dac_ctl_pkg::WAKE_CYC - 1);
         n.busy = 1'b1;
      end
      else if (q.cnt != 9'h000)
         n.cnt = q.cnt - 9'h001;
      else
         n.busy = 1'b0;
   end

   always_ff @(posedge i_ref_clk)
   begin
      if (i_srst)
         q <= '0;
      else
         q <= n;
   end

   assign o_busy = q.busy;
endmodule // wake_timer
`default_nettype wire

// *** rtl/dac_ctl.sv ***
// dual converter command decoder with register bus slave
//
// Implementation choices: the AXI4-Lite register port and the register offsets.
`timescale 1ns/100ps
`default_nettype none
module dac_ctl (
   input wire logic i_ref_clk,
   input wire logic i_srst,
   input wire logic i_frame_sel_n,
   input wire logic i_shift_clk,
   input wire logic i_serial_data,
   input wire logic [7:0] i_awaddr,
   input wire logic i_awvalid,
   output logic o_awready,
   input wire logic [31:0] i_wdata,
   input wire logic [3:0] i_wstrb,
   input wire logic i_wvalid,
   output logic o_wready,
   output logic [1:0] o_bresp,
   output logic o_bvalid,
   input wire logic i_bready,
   input wire logic [7:0] i_araddr,
   input wire logic i_arvalid,
   output logic o_arready,
   output logic [31:0] o_rdata,
   output logic [1:0] o_rresp,
   output logic o_rvalid,
   input wire logic i_rready,
   output logic [11:0] o_channel_a_output,
   output logic [11:0] o_channel_b_output,
   output logic [1:0] o_pd_mode_a,
   output logic [1:0] o_pd_mode_b,
   output logic o_wake_busy
);
   typedef struct packed {
      logic link_en;
      logic [11:0] hold_a;
      logic [11:0] hold_b;
      logic [11:0] dac_a;
      logic [11:0] dac_b;
      logic [1:0] pd_a;
      logic [1:0] pd_b;
      logic sw_pend;
      logic [15:0] sw_word;
      logic [3:0] last_cmd;
      logic [7:0] frames;
      logic aw_got;
      logic [7:0] aw_addr;
      logic w_got;
      logic [31:0] w_data;
      logic [3:0] w_strb;
      logic awready;
      logic wready;
      logic bvalid;
      logic [1:0] bresp;
      logic arready;
      logic rvalid;
      logic [31:0] rdata;
      logic [1:0] rresp;
   } core_t;

   core_t q;
   core_t n;
   logic exe;
   logic [15:0] word;
   logic [3:0] cmd;
   logic [11:0] code;
   logic sel_a;
   logic sel_b;
   logic wake_start;
   logic busy;

   frame_if frame ();

   link_rx u_rx (
      .i_ref_clk(i_ref_clk),
      .i_srst(i_srst),
      .i_link_en(q.link_en),
      .i_frame_sel_n(i_frame_sel_n),
      .i_shift_clk(i_shift_clk),
      .i_serial_data(i_serial_data),
      .frame(frame.rx)
   );

   wake_timer u_wake (
      .i_ref_clk(i_ref_clk),
      .i_srst(i_srst),
      .i_start(wake_start),
      .o_busy(busy)
   );

   function automatic logic [5:0] widx(input logic [7:0] a);
      return a[7:2];
   endfunction

   function automatic logic is_mapped(input logic [7:0] a);
      return widx(a) == widx(dac_ctl_pkg::OFF_CTRL)
         || widx(a) == widx(dac_ctl_pkg::OFF_CMD)
         || widx(a) == widx(dac_ctl_pkg::OFF_CHAN_A)
         || widx(a) == widx(dac_ctl_pkg::OFF_CHAN_B)
         || widx(a) == widx(dac_ctl_pkg::OFF_STATUS);
   endfunction

   function automatic logic [31:0] chan_word(input logic [11:0] h, input logic [11:0] d);
      return {4'h0, h, 4'h0, d};
   endfunction

   function automatic logic is_listed(input logic [3:0] c);
      return c inside {dac_ctl_pkg::CMD_XPAR_A, dac_ctl_pkg::CMD_XPAR_B,
         dac_ctl_pkg::CMD_HOLD_A, dac_ctl_pkg::CMD_HOLD_B,
         dac_ctl_pkg::CMD_XFER_A, dac_ctl_pkg::CMD_XFER_B,
         dac_ctl_pkg::CMD_XPAR_AB, dac_ctl_pkg::CMD_HOLD_AB,
         dac_ctl_pkg::CMD_XFER_AB, dac_ctl_pkg::CMD_POWER};
   endfunction

   // a link frame and a bus command in one cycle: the bus one waits a cycle
   always_comb
   begin
      exe = 1'b0;
      word = q.sw_word;
      if (frame.valid)
      begin
         exe = 1'b1;
         word = frame.word;
      end
      else if (q.sw_pend)
      begin
         exe = 1'b1;
      end
   end

   assign cmd = word[15:12];
   assign code = word[11:0];
   assign sel_a = code[dac_ctl_pkg::PWR_BOTH_BIT] || !code[dac_ctl_pkg::PWR_SEL_B_BIT];
   assign sel_b = code[dac_ctl_pkg::PWR_BOTH_BIT] || code[dac_ctl_pkg::PWR_SEL_B_BIT];

   always_comb
   begin
      n = q;
      wake_start = 1'b0;
      if (exe)
      begin
         if (!frame.valid)
            n.sw_pend = 1'b0;
         n.last_cmd = cmd;
         n.frames = q.frames + 8'h01;
         // input register made transparent: both stages take the code
         unique case (cmd)
            dac_ctl_pkg::CMD_XPAR_A:
            begin
               n.hold_a = code;
               n.dac_a = code;
            end
            dac_ctl_pkg::CMD_XPAR_B:
            begin
               n.hold_b = code;
               n.dac_b = code;
            end
            dac_ctl_pkg::CMD_HOLD_A:
               n.hold_a = code;
            dac_ctl_pkg::CMD_HOLD_B:
               n.hold_b = code;
            dac_ctl_pkg::CMD_XFER_A:
               n.dac_a = q.hold_a;
            dac_ctl_pkg::CMD_XFER_B:
               n.dac_b = q.hold_b;
            dac_ctl_pkg::CMD_XPAR_AB:
            begin
               n.hold_a = code;
               n.hold_b = code;
               n.dac_a = code;
               n.dac_b = code;
            end
            dac_ctl_pkg::CMD_HOLD_AB:
            begin
               n.hold_a = code;
               n.hold_b = code;
            end
            dac_ctl_pkg::CMD_XFER_AB:
            begin
               n.dac_a = q.hold_a;
               n.dac_b = q.hold_b;
            end
            dac_ctl_pkg::CMD_POWER:
            begin
               // no gating: power commands run even while recovering
               if (sel_a)
                  n.pd_a = code[1:0];
               if (sel_b)
                  n.pd_b = code[1:0];
               wake_start = code[1:0] == dac_ctl_pkg::PD_WAKE
                  && ((sel_a && q.pd_a != dac_ctl_pkg::PD_WAKE)
                  || (sel_b && q.pd_b != dac_ctl_pkg::PD_WAKE));
            end
            default:
               n.last_cmd = cmd;
         endcase
      end

      if (q.awready && i_awvalid)
      begin
         n.aw_got = 1'b1;
         n.aw_addr = i_awaddr;
      end
      if (q.wready && i_wvalid)
      begin
         n.w_got = 1'b1;
         n.w_data = i_wdata;
         n.w_strb = i_wstrb;
      end
      if (q.bvalid && i_bready)
         n.bvalid = 1'b0;
      if (n.aw_got && n.w_got && !q.bvalid)
      begin
         n.aw_got = 1'b0;
         n.w_got = 1'b0;
         n.bvalid = 1'b1;
         n.bresp = is_mapped(n.aw_addr) ? dac_ctl_pkg::RESP_OKAY : dac_ctl_pkg::RESP_DECERR;
         if (widx(n.aw_addr) == widx(dac_ctl_pkg::OFF_CTRL) && n.w_strb[0])
            n.link_en = n.w_data[dac_ctl_pkg::CTRL_EN_BIT];
         if (widx(n.aw_addr) == widx(dac_ctl_pkg::OFF_CMD) && n.w_strb[1:0] == 2'h3)
         begin
            n.sw_pend = 1'b1;
            n.sw_word = n.w_data[15:0];
         end
      end
      n.awready = !n.aw_got && !n.bvalid;
      n.wready = !n.w_got && !n.bvalid;

      if (q.rvalid && i_rready)
         n.rvalid = 1'b0;
      if (q.arready && i_arvalid)
      begin
         n.rvalid = 1'b1;
         n.rresp = dac_ctl_pkg::RESP_OKAY;
         n.rdata = 32'h0000_0000;
         unique case (widx(i_araddr))
            widx(dac_ctl_pkg::OFF_CTRL):
               n.rdata = {31'h0000_0000, q.link_en};
            widx(dac_ctl_pkg::OFF_CMD):
               n.rdata = {15'h0000, q.sw_pend, q.sw_word};
            widx(dac_ctl_pkg::OFF_CHAN_A):
               n.rdata = chan_word(q.hold_a, q.dac_a);
            widx(dac_ctl_pkg::OFF_CHAN_B):
               n.rdata = chan_word(q.hold_b, q.dac_b);
            widx(dac_ctl_pkg::OFF_STATUS):
               n.rdata = {8'h00, q.frames, 4'h0, q.last_cmd,
                  2'h0, frame.armed, busy, q.pd_b, q.pd_a};
            default:
               n.rresp = dac_ctl_pkg::RESP_DECERR;
         endcase
      end
      n.arready = !n.rvalid;
   end

   always_ff @(posedge i_ref_clk)
   begin
      if (i_srst)
      begin
         q <= '0;
         q.link_en <= dac_ctl_pkg::CTRL_EN_RST;
         q.hold_a <= dac_ctl_pkg::CODE_RST;
         q.hold_b <= dac_ctl_pkg::CODE_RST;
         q.dac_a <= dac_ctl_pkg::CODE_RST;
         q.dac_b <= dac_ctl_pkg::CODE_RST;
         q.pd_a <= dac_ctl_pkg::PD_RST;
         q.pd_b <= dac_ctl_pkg::PD_RST;
      end
      else
      begin
         q <= n;
      end
   end

   assign o_awready = q.awready;
   assign o_wready = q.wready;
   assign o_bresp = q.bresp;
   assign o_bvalid = q.bvalid;
   assign o_arready = q.arready;
   assign o_rdata = q.rdata;
   assign o_rresp = q.rresp;
   assign o_rvalid = q.rvalid;
   assign o_channel_a_output = q.dac_a;
   assign o_channel_b_output = q.dac_b;
   assign o_pd_mode_a = q.pd_a;
   assign o_pd_mode_b = q.pd_b;
   assign o_wake_busy = busy;

   default clocking cb @(posedge i_ref_clk); endclocking
   default disable iff (i_srst);

   reset_clear_a: assert property (disable iff (1'b0) $past(i_srst) |->
      q.dac_a == 12'h000 && q.dac_b == 12'h000 && q.hold_a == 12'h000
      && q.hold_b == 12'h000 && q.pd_a == 2'h3 && q.pd_b == 2'h3)
      else $error("reset state wrong");

   xparent_load_a: assert property (exe && cmd == 4'h0 |=>
      q.dac_a == $past(code) && $stable(q.dac_b))
      else $error("transparent load A wrong");

   xparent_load_b_a: assert property (exe && cmd == 4'h1 |=>
      q.dac_b == $past(code) && $stable(q.dac_a))
      else $error("transparent load B wrong");

   hold_only_b_a: assert property (exe && cmd == 4'h5 |=>
      q.hold_b == $past(code) && $stable(q.dac_b) && $stable(q.dac_a))
      else $error("holding load B touched output");

   xfer_one_a: assert property (exe && cmd == 4'h8 ##1 1'b1 |->
      q.dac_a == $past(q.hold_a) && $stable(q.hold_a))
      else $error("transfer A wrong");

   xfer_one_b_a: assert property (exe && cmd == 4'h9 |=>
      q.dac_b == $past(q.hold_b) && $stable(q.dac_a))
      else $error("transfer B wrong");

   xparent_both_a: assert property (exe && cmd == 4'hC |=>
      q.dac_a == $past(code) && q.dac_b == $past(code))
      else $error("dual transparent load wrong");

   hold_both_a: assert property (exe && cmd == 4'hD |=>
      q.hold_a == $past(code) && q.hold_b == $past(code) && $stable(q.dac_a) && $stable(q.dac_b))
      else $error("dual holding load wrong");

   xfer_both_a: assert property (exe && cmd == 4'hE |=>
      q.dac_a == $past(q.hold_a) && q.dac_b == $past(q.hold_b))
      else $error("dual transfer wrong");

   power_sel_a: assert property (exe && cmd == 4'hF && !code[4] && code[2] |=>
      q.pd_b == $past(code[1:0]) && $stable(q.pd_a) && $stable(q.dac_b))
      else $error("power select B wrong");

   power_keep_a: assert property (exe && cmd == 4'hF |=>
      $stable(q.dac_a) && $stable(q.hold_a) && $stable(q.dac_b) && $stable(q.hold_b))
      else $error("power command changed registers");

   unlisted_cmd_a: assert property (exe && !is_listed(cmd) |=>
      $stable(q.dac_a) && $stable(q.dac_b) && $stable(q.hold_a) && $stable(q.hold_b)
      && $stable(q.pd_a) && $stable(q.pd_b))
      else $error("unlisted command had effect");

   output_cause_a: assert property ($changed(q.dac_a) |->
      $past(exe) && $past(cmd) inside {4'h0, 4'h8, 4'hC, 4'hE})
      else $error("output changed without output write");

   wake_timer_a: assert property (wake_start |=> busy [*8])
      else $error("recovery flag dropped early");
endmodule // dac_ctl
`default_nettype wire

// *** bench/host_link_model.sv ***
// serial master model that frames 16-bit command words onto the link
`timescale 1ns/100ps
`default_nettype none
module host_link_model (
   input wire logic i_ref_clk,
   output logic o_frame_sel_n,
   output logic o_shift_clk,
   output logic o_serial_data
);
   // 160 ns link clock: four reference cycles per phase
   localparam int HALF = 4;

   initial
   begin
      o_frame_sel_n = 1'b1;
      o_shift_clk = 1'b1;
      o_serial_data = 1'b0;
   end

   task automatic half_wait();
      repeat (HALF) @(posedge i_ref_clk);
   endtask

   // extra clocks carry the inverted word, so a receiver that keeps listening corrupts state
   task automatic send_frame(input logic [15:0] w, input int nbits, input int extra);
      int i;
      o_frame_sel_n <= 1'b0;
      half_wait();
      for (i = 0; i < nbits + extra; i++)
      begin
         o_serial_data <= (i < 16) ? w[15 - i] : ~w[15 - (i % 16)];
         half_wait();
         o_shift_clk <= 1'b0;
         half_wait();
         o_shift_clk <= 1'b1;
      end
      half_wait();
      o_frame_sel_n <= 1'b1;
      // released data line has no pull, so show the inverse rather than a stale bit
      o_serial_data <= ~o_serial_data;
      half_wait();
   endtask
endmodule // host_link_model
`default_nettype wire

// *** bench/dual_dac_serial_command_decoder_tb.sv ***
// self-checking bench for the dual converter command decoder
`timescale 1ns/100ps
`default_nettype none
module dual_dac_serial_command_decoder_tb;
   logic clk, srst, awvalid, wvalid, bready, arvalid, rready;
   logic [7:0] awaddr, araddr;
   logic [31:0] wdata, d;
   logic [3:0] wstrb;
   logic [1:0] r;
   logic [15:0] w;
   wire logic sel_n, sclk, sdata;
   logic o_awready, o_wready, o_bvalid, o_arready, o_rvalid, o_wake_busy;
   logic [1:0] o_bresp, o_rresp, o_pd_mode_a, o_pd_mode_b;
   logic [31:0] o_rdata;
   logic [11:0] o_channel_a_output, o_channel_b_output;
   logic [11:0] hold_e [2];
   logic [11:0] out_e [2];
   logic [1:0] pd_e [2];
   int num_errors, tests_run, i;

   host_link_model host (.i_ref_clk(clk), .o_frame_sel_n(sel_n), .o_shift_clk(sclk),
      .o_serial_data(sdata));

   dac_ctl dut (.i_ref_clk(clk), .i_srst(srst), .i_frame_sel_n(sel_n), .i_shift_clk(sclk),
      .i_serial_data(sdata), .i_awaddr(awaddr), .i_awvalid(awvalid), .o_awready(o_awready),
      .i_wdata(wdata), .i_wstrb(wstrb), .i_wvalid(wvalid), .o_wready(o_wready),
      .o_bresp(o_bresp), .o_bvalid(o_bvalid), .i_bready(bready), .i_araddr(araddr),
      .i_arvalid(arvalid), .o_arready(o_arready), .o_rdata(o_rdata), .o_rresp(o_rresp),
      .o_rvalid(o_rvalid), .i_rready(rready), .o_channel_a_output(o_channel_a_output),
      .o_channel_b_output(o_channel_b_output), .o_pd_mode_a(o_pd_mode_a),
      .o_pd_mode_b(o_pd_mode_b), .o_wake_busy(o_wake_busy));

   initial
   begin
      clk = 1'b0;
      forever #10 clk = ~clk;
   end

   task automatic report_and_stop();
      $display("comparisons %0d mismatches %0d", tests_run, num_errors);
      if (num_errors == 0 && tests_run > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask

   task automatic timed_out();
      num_errors++;
      $display("MISMATCH bus wait expected answer seen none");
      report_and_stop();
   endtask

   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      tests_run++;
      if (seen !== exp)
      begin
         num_errors++;
         $display("MISMATCH %s expected %h seen %h", what, exp, seen);
      end
   endtask

   task automatic axi_write(input logic [7:0] a, input logic [31:0] v, output logic [1:0] rs);
      int n;
      logic got;
      got = 1'b0;
      awaddr <= a;
      wdata <= v;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      for (n = 0; n < 100 && !got; n++)
      begin
         @(posedge clk);
         if (o_awready === 1'b1)
            awvalid <= 1'b0;
         if (o_wready === 1'b1)
            wvalid <= 1'b0;
         if (o_bvalid === 1'b1)
         begin
            got = 1'b1;
            rs = o_bresp;
            bready <= 1'b0;
         end
      end
      if (!got)
         timed_out();
      @(posedge clk);
   endtask

   task automatic axi_read(input logic [7:0] a, output logic [31:0] v, output logic [1:0] rs);
      int n;
      logic got;
      got = 1'b0;
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      for (n = 0; n < 100 && !got; n++)
      begin
         @(posedge clk);
         if (o_arready === 1'b1)
            arvalid <= 1'b0;
         if (o_rvalid === 1'b1)
         begin
            got = 1'b1;
            v = o_rdata;
            rs = o_rresp;
            rready <= 1'b0;
         end
      end
      if (!got)
         timed_out();
      @(posedge clk);
   endtask

   // unlisted command nibbles fall to the default and change nothing
   function automatic void predict(input logic [15:0] cw);
      logic [11:0] c;
      logic s;
      c = cw[11:0];
      s = cw[12];
      case (cw[15:12])
         4'h0, 4'h1:
         begin
            hold_e[s] = c;
            out_e[s] = c;
         end
         4'h4, 4'h5: hold_e[s] = c;
         4'h8, 4'h9: out_e[s] = hold_e[s];
         4'hC:
         begin
            hold_e = '{c, c};
            out_e = '{c, c};
         end
         4'hD: hold_e = '{c, c};
         4'hE: out_e = hold_e;
         4'hF:
            if (c[4])
               pd_e = '{c[1:0], c[1:0]};
            else
               pd_e[c[2]] = c[1:0];
         default: ;
      endcase
   endfunction

   task automatic check_all();
      logic [31:0] v;
      logic [1:0] rs;
      check("out_a", {20'h0, o_channel_a_output}, {20'h0, out_e[0]});
      check("out_b", {20'h0, o_channel_b_output}, {20'h0, out_e[1]});
      check("pd", {28'h0, o_pd_mode_b, o_pd_mode_a}, {28'h0, pd_e[1], pd_e[0]});
      axi_read(8'h08, v, rs);
      check("chan_a", v, {4'h0, hold_e[0], 4'h0, out_e[0]});
      axi_read(8'h0C, v, rs);
      check("chan_b", v, {4'h0, hold_e[1], 4'h0, out_e[1]});
   endtask

   task automatic frame(input logic [15:0] cw, input int nbits, input int extra, input bit take);
      host.send_frame(cw, nbits, extra);
      if (take)
         predict(cw);
      repeat (10) @(posedge clk);
      check_all();
   endtask

   initial
   begin
      srst = 1'b1;
      {awvalid, wvalid, bready, arvalid, rready} = 5'h00;
      awaddr = 8'h00;
      araddr = 8'h00;
      wdata = 32'h0;
      wstrb = 4'hF;
      hold_e = '{12'h000, 12'h000};
      out_e = '{12'h000, 12'h000};
      pd_e = '{2'h3, 2'h3};
      num_errors = 0;
      tests_run = 0;
      void'($urandom(34872));
      repeat (20) @(posedge clk);
      srst <= 1'b0;
      repeat (5) @(posedge clk);
      check_all();
      frame(16'hF010, 16, 0, 1);
      check("wake_busy", {31'h0, o_wake_busy}, 32'h1);
      repeat (420) @(posedge clk);
      check("wake_busy", {31'h0, o_wake_busy}, 32'h0);
      frame(16'h0FFF, 16, 0, 1);
      frame(16'h1000, 16, 0, 1);
      frame(16'h4ABC, 16, 0, 1);
      frame(16'h5123, 16, 0, 1);
      frame(16'hE000, 16, 0, 1);
      for (i = 0; i < 40; i++)
      begin
         w = {(i < 16) ? i[3:0] : 4'($urandom), 12'($urandom)};
         frame(w, 16, 0, 1);
         if (w[15:12] == 4'hF)
            repeat (420) @(posedge clk);
      end
      frame(16'h0555, 10, 0, 0);
      // a full inverted word after the sixteenth bit: a receiver still listening would act on it
      frame(16'h1777, 16, 16, 1);
      axi_write(8'h04, 32'h0000C321, r);
      check("cmd_resp", {30'h0, r}, {30'h0, dac_ctl_pkg::RESP_OKAY});
      predict(16'hC321);
      repeat (10) @(posedge clk);
      check_all();
      wstrb <= 4'h1;
      axi_write(8'h04, 32'h0000C000, r);
      wstrb <= 4'hF;
      repeat (10) @(posedge clk);
      check_all();
      axi_write(8'h20, 32'h0000FFFF, r);
      check("bad_wr", {30'h0, r}, {30'h0, dac_ctl_pkg::RESP_DECERR});
      axi_read(8'h20, d, r);
      check("bad_rd", {r, d[29:0]}, {dac_ctl_pkg::RESP_DECERR, 30'h0});
      axi_read(8'h10, d, r);
      check("status", {28'h0, d[3:0]}, {28'h0, pd_e[1], pd_e[0]});
      axi_write(8'h00, 32'h0, r);
      frame(16'h0ABC, 16, 0, 0);
      axi_write(8'h00, 32'h1, r);
      frame(16'h8000, 16, 0, 1);
      srst <= 1'b1;
      repeat (3) @(posedge clk);
      srst <= 1'b0;
      repeat (5) @(posedge clk);
      hold_e = '{12'h000, 12'h000};
      out_e = '{12'h000, 12'h000};
      pd_e = '{2'h3, 2'h3};
      check_all();
      check("wake_rst", {31'h0, o_wake_busy}, 32'h0);
      axi_read(8'h00, d, r);
      check("ctrl_rst", d, 32'h0000_0001);
      frame(16'h0ABC, 16, 0, 1);
      report_and_stop();
   end
endmodule // dual_dac_serial_command_decoder_tb
`default_nettype wire
